// file: design/ucd_top.sv
// One asynchronous serial channel: registers, double-buffered receive and transmit paths.
// Assumes a one-cycle register port and serial pins synchronous to i_clk.
`timescale 1ns/10ps
`include "ucd_regs.svh"
module ucd_top #(
   parameter int CHANNEL = 0
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_rxd,
   input  wire logic       i_ext_sclk,
   output logic      [7:0] o_rdata,
   output logic            o_txd,
   output logic            o_rx_irq,
   output logic            o_tx_irq
);
   import ucd_pkg::*;

   // Bit order: identity for LSB first, reversed for MSB first (self-inverse)
   function automatic logic [7:0] order_bits(input logic [7:0] d, input logic [7:0] ctl);
      logic [7:0] v;
      v = d;
      if (!ctl[`UCD_CTL_DIR])
         for (int i = 0; i < 8; i++)
            v[i] = ctl[`UCD_CTL_CL] ? d[7 - i] : ((i < 7) ? d[6 - i] : 1'b0);
      return v;
   endfunction

   // Frame length in bits including start and stop bits
   function automatic logic [4:0] frame_len(input logic [7:0] ctl);
      return 5'h01 + (ctl[`UCD_CTL_CL] ? 5'h08 : 5'h07)
             + {4'h0, |ctl[`UCD_CTL_PS1:`UCD_CTL_PS0]} + (ctl[`UCD_CTL_SL] ? 5'h02 : 5'h01);
   endfunction

   // Parity bit: zero, odd or even over the data bits
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] ctl);
      case (ctl[`UCD_CTL_PS1:`UCD_CTL_PS0])
         2'b10:   return ~^d;
         2'b11:   return ^d;
         default: return 1'b0;
      endcase
   endfunction

   // Full frame, first bit out in bit 0
   function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [7:0] ctl);
      logic [11:0] v;
      logic [7:0]  od;
      logic [3:0]  nb;
      v = 12'hFFF;
      od = order_bits(d, ctl);
      nb = ctl[`UCD_CTL_CL] ? 4'h8 : 4'h7;
      v[0] = 1'b0;
      for (int i = 0; i < 8; i++)
         if (i < int'(nb))
            v[1 + i] = od[i];
      if (|ctl[`UCD_CTL_PS1:`UCD_CTL_PS0])
         v[nb + 4'h1] = par_bit(d & (ctl[`UCD_CTL_CL] ? 8'hFF : 8'h7F), ctl);
      return v;
   endfunction

   ucd_st_t     r;
   ucd_st_t     n;
   logic        tick;
   logic        rx_line;
   logic [7:0]  dv;
   logic        pwr;
   logic        tx_on;
   logic        rx_on;
   logic        tx_wr_ok;
   logic        rd_rx;
   logic        rx_done;
   logic        tx_load;
   logic        bit_out;
   logic [4:0]  rx_need;
   logic [11:0] sh_new;
   logic [7:0]  rx_data;
   logic        rx_par;

   // Base clock enable from the clock select register
   ucd_baud_gen #(
      .CHANNEL   (CHANNEL)
   ) u_baud (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_en      (r.ctl[`UCD_CTL_PWR]),
      .i_sel     (r.bcs[3:0]),
      .i_ext_sclk(i_ext_sclk),
      .o_tick    (tick)
   );

   // Input inversion ahead of the noise filter
   ucd_rx_filter u_filt (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_din (i_rxd ^ r.opt[`UCD_OPT_RINV]),
      .o_dout(rx_line)
   );

   // Next state of the whole channel
   always_comb
   begin
      n = r;
      pwr = r.ctl[`UCD_CTL_PWR];
      tx_on = pwr & r.ctl[`UCD_CTL_TXE];
      rx_on = pwr & r.ctl[`UCD_CTL_RXE];
      dv = (r.div < `UCD_DIV_MIN) ? `UCD_DIV_MIN : r.div;
      tx_wr_ok = i_wr && i_addr == `UCD_ADDR_TXB && tx_on && !r.tx_full;
      rd_rx = i_rd && i_addr == `UCD_ADDR_RXB;
      rx_done = 1'b0;
      tx_load = 1'b0;
      rx_need = frame_len(r.ctl) - (r.ctl[`UCD_CTL_SL] ? 5'h02 : 5'h01);
      sh_new = r.rx_sh;
      sh_new[r.rx_idx] = rx_line;
      rx_data = order_bits(sh_new[7:0] & (r.ctl[`UCD_CTL_CL] ? 8'hFF : 8'h7F), r.ctl);
      rx_par = r.ctl[`UCD_CTL_CL] ? sh_new[8] : sh_new[7];
      n.rdata = 8'h00;

      // Register writes; status bits clear on a one
      if (i_wr)
         case (i_addr)
            `UCD_ADDR_CTL: n.ctl = i_wdata;
            `UCD_ADDR_BCS: n.bcs = i_wdata;
            `UCD_ADDR_DIV: n.div = i_wdata;
            `UCD_ADDR_OPT: n.opt = i_wdata;
            `UCD_ADDR_STS: n.sts = r.sts & ~i_wdata[3:0];
            default: ;
         endcase
      if (tx_wr_ok)
      begin
         n.txb = i_wdata;
         n.tx_full = 1'b1;
      end
      if (rd_rx)
         n.rx_full = 1'b0;

      // Transmit path
      if (!tx_on)
      begin
         n.tx_busy = 1'b0;
         n.tx_full = 1'b0;
         n.opt[`UCD_OPT_SBT] = 1'b0;
      end
      else if (r.tx_busy)
      begin
         if (tick)
         begin
            if (r.tx_cnt >= dv - 8'h01)
            begin
               n.tx_cnt = 8'h00;
               n.tx_sh = {1'b1, r.tx_sh[11:1]};
               n.tx_left = r.tx_left - 5'h01;
               if (r.tx_left == 5'h01)
               begin
                  n.tx_busy = 1'b0;
                  if (r.tx_brk)
                     n.opt[`UCD_OPT_SBT] = 1'b0;
               end
            end
            else
               n.tx_cnt = r.tx_cnt + 8'h01;
         end
      end
      else if (r.opt[`UCD_OPT_SBT])
      begin
         // Break field: 13 plus the length select field, then one stop bit
         n.tx_busy = 1'b1;
         n.tx_brk = 1'b1;
         n.tx_cnt = 8'h00;
         n.tx_left = `UCD_SBF_TX_BASE + {2'b00, r.opt[`UCD_OPT_SBL_HI:`UCD_OPT_SBL_LO]} + 5'h01;
      end
      else if (r.tx_full)
      begin
         tx_load = 1'b1;
         n.tx_full = 1'b0;
         n.tx_busy = 1'b1;
         n.tx_brk = 1'b0;
         n.tx_cnt = 8'h00;
         n.tx_sh = tx_frame(r.txb, r.ctl);
         n.tx_left = frame_len(r.ctl);
      end

      // Line level: idle high unless inverted, break low until its stop bit
      bit_out = n.tx_busy ? (n.tx_brk ? (n.tx_left <= 5'h01) : n.tx_sh[0]) : 1'b1;
      n.txd = bit_out ^ r.opt[`UCD_OPT_TINV];

      // Receive path
      if (!rx_on)
         n.rx_st = RX_IDLE;
      else if (tick)
         case (r.rx_st)
            RX_IDLE:
               if (!rx_line)
               begin
                  n.rx_st = RX_START;
                  n.rx_cnt = 8'h00;
               end
            RX_START:
               if (r.rx_cnt >= {1'b0, dv[7:1]})
               begin
                  n.rx_st = rx_line ? RX_IDLE : RX_BITS;
                  n.rx_cnt = 8'h00;
                  n.rx_idx = 4'h0;
                  n.rx_sh = 12'h000;
               end
               else
                  n.rx_cnt = r.rx_cnt + 8'h01;
            RX_BITS:
               if (r.rx_cnt >= dv - 8'h01)
               begin
                  n.rx_cnt = 8'h00;
                  n.rx_sh = sh_new;
                  n.rx_idx = r.rx_idx + 4'h1;
                  if ({1'b0, r.rx_idx} == rx_need - 5'h01)
                  begin
                     if (!rx_line && r.rx_sh == 12'h000)
                     begin
                        n.rx_st = RX_BREAK;
                        n.brk_cnt = rx_need + 5'h01;
                     end
                     else
                     begin
                        n.rx_st = RX_IDLE;
                        rx_done = 1'b1;
                        n.rxb = rx_data;
                        n.rx_full = 1'b1;
                        if (!rx_line)
                           n.sts[`UCD_STS_FE] = 1'b1;
                        if (r.ctl[`UCD_CTL_PS1] && rx_par != par_bit(rx_data, r.ctl))
                           n.sts[`UCD_STS_PE] = 1'b1;
                        if (r.rx_full && !rd_rx)
                           n.sts[`UCD_STS_OVE] = 1'b1;
                     end
                  end
               end
               else
                  n.rx_cnt = r.rx_cnt + 8'h01;
            RX_BREAK:
               if (r.rx_cnt >= dv - 8'h01)
               begin
                  n.rx_cnt = 8'h00;
                  if (!rx_line)
                     n.brk_cnt = (r.brk_cnt == 5'h1F) ? r.brk_cnt : r.brk_cnt + 5'h01;
                  else
                  begin
                     n.rx_st = RX_IDLE;
                     if (r.brk_cnt >= `UCD_BRK_MIN_BITS)
                        n.sts[`UCD_STS_BRK] = 1'b1;
                     else
                        n.sts[`UCD_STS_FE] = 1'b1;
                  end
               end
               else
                  n.rx_cnt = r.rx_cnt + 8'h01;
            default: n.rx_st = RX_IDLE;
         endcase

      // Power off clears the status flags and the receive full flag
      if (!pwr)
      begin
         n.sts = 4'h0;
         n.rx_full = 1'b0;
      end
      n.rx_irq = rx_done;
      n.tx_irq = tx_load;

      // Read data for the cycle after the strobe
      if (i_rd)
         case (i_addr)
            `UCD_ADDR_CTL: n.rdata = r.ctl;
            `UCD_ADDR_BCS: n.rdata = r.bcs;
            `UCD_ADDR_DIV: n.rdata = r.div;
            `UCD_ADDR_OPT: n.rdata = r.opt;
            `UCD_ADDR_STS: n.rdata = {r.tx_busy | r.tx_full, 3'b000, r.sts};
            `UCD_ADDR_RXB: n.rdata = r.rxb;
            `UCD_ADDR_TXB: n.rdata = r.txb;
            default:       n.rdata = 8'h00;
         endcase
   end

   // State register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         r <= '0;
         r.ctl <= `UCD_RST_CTL;
         r.bcs <= `UCD_RST_BCS;
         r.div <= `UCD_RST_DIV;
         r.opt <= `UCD_RST_OPT;
         r.rx_st <= RX_IDLE;
         r.txd <= 1'b1;
      end
      else
         r <= n;
   end

   assign o_rdata = r.rdata;
   assign o_txd = r.txd;
   assign o_rx_irq = r.rx_irq;
   assign o_tx_irq = r.tx_irq;

   // Checks on the datapaths
   sequence s_wr_idle;
      tx_wr_ok && !r.tx_busy && !r.opt[`UCD_OPT_SBT];
   endsequence
   sequence s_still_on;
      tx_on && !r.opt[`UCD_OPT_SBT];
   endsequence
   property p_rx_en;
      @(posedge i_clk) disable iff (i_rst) o_rx_irq |-> $past(rx_on);
   endproperty
   a_rx_en: assert property (p_rx_en) else $error("receive move while disabled");
   property p_rx_full;
      @(posedge i_clk) disable iff (i_rst) o_rx_irq |-> r.rx_full && r.rxb == $past(rx_data);
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("receive buffer not loaded");
   property p_tx_start;
      @(posedge i_clk) disable iff (i_rst) tx_wr_ok |=> r.tx_full && r.txb == $past(i_wdata);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("transmit write lost");
   property p_tx_flow;
      @(posedge i_clk) disable iff (i_rst) s_wr_idle ##1 s_still_on |=> o_tx_irq && r.tx_busy;
   endproperty
   a_tx_flow: assert property (p_tx_flow) else $error("no handoff to shifter");
   property p_tx_irq;
      @(posedge i_clk) disable iff (i_rst) o_tx_irq |-> !r.tx_full && r.tx_busy && !r.tx_brk;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("buffer free pulse without load");
   property p_ovr;
      @(posedge i_clk) disable iff (i_rst) (rx_done && r.rx_full && !rd_rx && pwr) |=> r.sts[0];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");
   property p_brk;
      @(posedge i_clk) disable iff (i_rst) $rose(r.sts[3]) |-> $past(r.brk_cnt) >= 5'h0B;
   endproperty
   a_brk: assert property (p_brk) else $error("break flag on short low");
   property p_idle_pin;
      @(posedge i_clk) disable iff (i_rst) !pwr |=> o_txd == ~$past(r.opt[1]);
   endproperty
   a_idle_pin: assert property (p_idle_pin) else $error("output pin not idle when off");
   property p_start_bit;
      @(posedge i_clk) disable iff (i_rst) o_tx_irq |-> o_txd == $past(r.opt[1]);
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("frame not opened by start bit");
endmodule

// file: design/ucd_regs.svh
// Register offsets, field positions, reset values and counts of the serial channel.
// Assumes an 8-bit register port with a 3-bit address.
`ifndef UCD_REGS_SVH
`define UCD_REGS_SVH

// Register offsets
`define UCD_ADDR_CTL 3'h0
`define UCD_ADDR_BCS 3'h1
`define UCD_ADDR_DIV 3'h2
`define UCD_ADDR_OPT 3'h3
`define UCD_ADDR_STS 3'h4
`define UCD_ADDR_RXB 3'h5
`define UCD_ADDR_TXB 3'h6

// Main control fields
`define UCD_CTL_PWR 7
`define UCD_CTL_TXE 6
`define UCD_CTL_RXE 5
`define UCD_CTL_DIR 4
`define UCD_CTL_PS1 3
`define UCD_CTL_PS0 2
`define UCD_CTL_CL 1
`define UCD_CTL_SL 0

// Option fields
`define UCD_OPT_SBT 7
`define UCD_OPT_SBL_HI 5
`define UCD_OPT_SBL_LO 3
`define UCD_OPT_TINV 1
`define UCD_OPT_RINV 0

// Status fields
`define UCD_STS_TBSY 7
`define UCD_STS_BRK 3
`define UCD_STS_PE 2
`define UCD_STS_FE 1
`define UCD_STS_OVE 0

// Reset values
`define UCD_RST_CTL 8'h10
`define UCD_RST_BCS 8'h00
`define UCD_RST_DIV 8'h10
`define UCD_RST_OPT 8'h00

// Counts
`define UCD_BRK_MIN_BITS 5'h0B
`define UCD_SBF_TX_BASE 5'h0D
`define UCD_DIV_MIN 8'h04
`define UCD_PRE_MAX 4'hA
`define UCD_EXT_SEL 4'hB

`endif

// file: design/ucd_pkg.sv
// Types shared by the serial channel modules.
// Assumes the constants of ucd_regs.svh.
package ucd_pkg;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_BREAK} ucd_rx_st_t;

   typedef struct packed {
      logic [9:0] pre;
      logic       ext_d;
      logic       tick;
   } ucd_bg_t;

   typedef struct packed {
      logic [1:0] hist;
      logic       out;
   } ucd_flt_t;

   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  bcs;
      logic [7:0]  div;
      logic [7:0]  opt;
      logic [3:0]  sts;
      logic [7:0]  rxb;
      logic [7:0]  txb;
      logic        rx_full;
      logic        tx_full;
      logic        tx_busy;
      logic        tx_brk;
      logic [11:0] tx_sh;
      logic [4:0]  tx_left;
      logic [7:0]  tx_cnt;
      ucd_rx_st_t  rx_st;
      logic [7:0]  rx_cnt;
      logic [3:0]  rx_idx;
      logic [11:0] rx_sh;
      logic [4:0]  brk_cnt;
      logic [7:0]  rdata;
      logic        txd;
      logic        rx_irq;
      logic        tx_irq;
   } ucd_st_t;

endpackage

// file: design/ucd_baud_gen.sv
// Base clock enable of the channel: a power-of-two prescaler or the external clock pin.
// Assumes i_ext_sclk is synchronous to i_clk; only channel zero honours it.
`timescale 1ns/10ps
`include "ucd_regs.svh"
module ucd_baud_gen #(
   parameter int CHANNEL = 0
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_en,
   input  wire logic [3:0] i_sel,
   input  wire logic       i_ext_sclk,
   output logic            o_tick
);
   import ucd_pkg::*;

   ucd_bg_t r;
   ucd_bg_t n;
   logic [3:0] sel_c;

   // Prescale by 2^sel with sel capped at 10, or follow rising edges of the external clock
   always_comb
   begin
      n = r;
      n.tick = 1'b0;
      n.ext_d = i_ext_sclk;
      sel_c = (i_sel > `UCD_PRE_MAX) ? `UCD_PRE_MAX : i_sel;
      if (!i_en)
      begin
         n.pre = 10'h000;
      end
      else if (i_sel == `UCD_EXT_SEL && CHANNEL == 0)
      begin
         n.tick = i_ext_sclk & ~r.ext_d;
      end
      else if (r.pre >= ((10'h001 << sel_c) - 10'h001))
      begin
         n.pre = 10'h000;
         n.tick = 1'b1;
      end
      else
      begin
         n.pre = r.pre + 10'h001;
      end
   end

   // State register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         r <= '{pre: 10'h000, ext_d: 1'b0, tick: 1'b0};
      else
         r <= n;
   end

   assign o_tick = r.tick;
endmodule

// file: design/ucd_rx_filter.sv
// Digital noise filter on the serial input: a level passes after three equal samples.
// Assumes the input is synchronous to i_clk and already corrected for inversion.
`timescale 1ns/10ps
module ucd_rx_filter (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_din,
   output logic      o_dout
);
   import ucd_pkg::*;

   ucd_flt_t r;
   ucd_flt_t n;

   // Take a new level only when it has held for three samples
   always_comb
   begin
      n = r;
      n.hist = {r.hist[0], i_din};
      if (r.hist[1] == r.hist[0] && r.hist[0] == i_din)
         n.out = i_din;
   end

   // State register, idle line after reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         r <= '{hist: 2'b11, out: 1'b1};
      else
         r <= n;
   end

   assign o_dout = r.out;
endmodule

// file: dv/ucd_remote.sv
// Remote serial transceiver: drives frames onto the channel input, captures output frames.
// Assumes one bit lasts i_bit_len clocks; the bench sets how many bits a frame holds.
`timescale 1ns/10ps
module ucd_remote (
   input  wire logic       i_clk,
   input  wire logic       i_txd,
   input  wire logic [7:0] i_bit_len,
   input  wire logic [3:0] i_nbits,
   output logic            o_rxd
);
   logic [15:0] caps [0:15];
   int          n_cap;
   logic [15:0] cap;
   int          i;

   // Line idles high between frames
   initial
   begin
      o_rxd = 1'b1;
      n_cap = 0;
   end

   // Sends n bits, bit 0 first, each held one bit time, then idles high
   task automatic send(input logic [15:0] bits, input int n);
      int k;
      for (k = 0; k < n; k++)
      begin
         o_rxd <= bits[k];
         repeat (i_bit_len) @(posedge i_clk);
      end
      o_rxd <= 1'b1;
   endtask

   // Captures a frame from its falling start edge, sampling each bit mid-way
   always
   begin
      @(negedge i_txd);
      repeat (i_bit_len / 2) @(posedge i_clk);
      cap = 16'hFFFF;
      for (i = 0; i < int'(i_nbits); i++)
      begin
         if (i > 0)
            repeat (i_bit_len) @(posedge i_clk);
         cap[i] = i_txd;
      end
      caps[n_cap[3:0]] = cap;
      n_cap++;
   end
endmodule

// file: dv/uart_channel_datapath_tb.sv
// Self-checking bench of one serial channel against a remote transceiver model.
// Assumes channel zero; base tick every clock unless a scenario selects otherwise.
`timescale 1ns/10ps
`include "ucd_regs.svh"
module uart_channel_datapath_tb;
   logic       clk;
   logic       rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       rxd;
   logic       ext_sclk;
   logic       ext_on;
   logic [7:0] rdata;
   logic       txd;
   logic       rx_irq;
   logic       tx_irq;
   logic [7:0] bit_len;
   logic [3:0] nbits;
   int         n_fail;
   int         total_checks;

   // Channel zero only; no timer requests share its lines here
   ucd_top #(.CHANNEL(0)) i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .i_rxd(rxd), .i_ext_sclk(ext_sclk), .o_rdata(rdata),
      .o_txd(txd), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq));
   ucd_remote i_remote (.i_clk(clk), .i_txd(txd), .i_bit_len(bit_len), .i_nbits(nbits),
      .o_rxd(rxd));

   // Clock and external base clock, one rising edge every two clocks
   always #5 clk = ~clk;
   always @(posedge clk) if (ext_on) ext_sclk <= ~ext_sclk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      check(what, 16'(rdata), 16'(exp));
   endtask

   task automatic wait_irq(input logic which, input int lim, output logic got);
      int k;
      got = 1'b0;
      for (k = 0; k < lim && !got; k++)
      begin
         @(posedge clk);
         got = ((which ? tx_irq : rx_irq) === 1'b1);
      end
   endtask

   // Expected line bits of one frame, first bit in bit 0; bad flips parity or a stop bit
   function automatic logic [15:0] frame(input logic [7:0] c, input logic [7:0] d,
                                         input logic [1:0] bad, output int n);
      logic p;
      int   nb;
      int   k;
      frame = 16'hFFFF;
      frame[0] = 1'b0;
      nb = c[1] ? 8 : 7;
      p = 1'b0;
      for (k = 0; k < nb; k++)
      begin
         frame[k + 1] = c[4] ? d[k] : d[nb - 1 - k];
         p = p ^ frame[k + 1];
      end
      n = nb + 1;
      if (c[3:2] != 2'b00)
      begin
         frame[n] = (c[3] & (c[2] ? p : ~p)) ^ bad[0];
         n++;
      end
      frame[n] = ~bad[1];
      n = n + (c[0] ? 2 : 1);
   endfunction

   // Power off, clock select and divisor, then power on and control
   task automatic cfg(input logic [7:0] c, input logic [7:0] bs, input logic [7:0] dv,
                      input logic [7:0] bl);
      reg_wr(`UCD_ADDR_CTL, 8'h00);
      reg_wr(`UCD_ADDR_BCS, bs);
      reg_wr(`UCD_ADDR_DIV, dv);
      reg_wr(`UCD_ADDR_CTL, 8'h80);
      reg_wr(`UCD_ADDR_CTL, c);
      bit_len = bl;
      rd_chk("divisor", `UCD_ADDR_DIV, dv);
   endtask

   task automatic t_reset;
      check("idle off", 16'(txd), 16'h1);
      rd_chk("ctl", `UCD_ADDR_CTL, `UCD_RST_CTL);
      rd_chk("bcs", `UCD_ADDR_BCS, `UCD_RST_BCS);
      rd_chk("div", `UCD_ADDR_DIV, `UCD_RST_DIV);
      rd_chk("opt", `UCD_ADDR_OPT, `UCD_RST_OPT);
      rd_chk("sts", `UCD_ADDR_STS, 8'h00);
      rd_chk("unmapped", 3'h7, 8'h00);
   endtask

   // Two characters back to back; the second waits in the buffer
   task automatic t_tx(input logic [7:0] c, input logic [7:0] bs, input logic [7:0] dv,
                       input logic [7:0] bl, input logic [7:0] d0, input logic [7:0] d1);
      int          n;
      int          base;
      int          k;
      logic        got;
      logic [15:0] f0;
      logic [15:0] f1;
      cfg(c, bs, dv, bl);
      f0 = frame(c, d0, 2'b00, n);
      f1 = frame(c, d1, 2'b00, n);
      nbits = n[3:0];
      base = i_remote.n_cap;
      reg_wr(`UCD_ADDR_TXB, d0);
      wait_irq(1'b1, 40, got);
      check("tx irq first", 16'(got), 16'h1);
      reg_wr(`UCD_ADDR_TXB, d1);
      rd_chk("tx busy", `UCD_ADDR_STS, 8'h80);
      wait_irq(1'b1, 400, got);
      check("tx irq second", 16'(got), 16'h1);
      for (k = 0; k < 400 && i_remote.n_cap < base + 2; k++)
         @(posedge clk);
      check("frame first", i_remote.caps[base[3:0]], f0);
      check("frame second", i_remote.caps[base[3:0] + 4'h1], f1);
   endtask

   task automatic t_rx(input logic [7:0] c, input logic [7:0] d, input logic [1:0] bad,
                       input logic [7:0] sts);
      int          n;
      logic        got;
      logic [15:0] f;
      cfg(c, 8'h00, 8'h04, 8'h04);
      f = frame(c, d, bad, n);
      fork
         i_remote.send(f, n);
         wait_irq(1'b0, 200, got);
      join
      if (bad == 2'b00)
         check("rx irq", 16'(got), 16'(c[5]));
      rd_chk("rx status", `UCD_ADDR_STS, sts);
      if (c[5] && bad == 2'b00)
         rd_chk("rx data", `UCD_ADDR_RXB, c[1] ? d : {1'b0, d[6:0]});
   endtask

   // Two characters with no read between them: overrun keeps the newer one
   task automatic t_ovr;
      int          n;
      logic [15:0] f;
      cfg(8'hF2, 8'h00, 8'h04, 8'h04);
      f = frame(8'hF2, 8'h11, 2'b00, n);
      i_remote.send(f, n);
      repeat (4) @(posedge clk);
      f = frame(8'hF2, 8'h22, 2'b00, n);
      i_remote.send(f, n);
      repeat (8) @(posedge clk);
      rd_chk("overrun flag", `UCD_ADDR_STS, 8'h01);
      rd_chk("overrun data", `UCD_ADDR_RXB, 8'h22);
   endtask

   // Break field sent: 13 low bits, one high bit, then the request clears itself
   task automatic t_sbt;
      int k;
      int base;
      cfg(8'hF2, 8'h00, 8'h04, 8'h04);
      nbits = 4'hE;
      base = i_remote.n_cap;
      reg_wr(`UCD_ADDR_OPT, 8'h80);
      for (k = 0; k < 100 && i_remote.n_cap == base; k++)
         @(posedge clk);
      repeat (8) @(posedge clk);
      check("break sent", i_remote.caps[base[3:0]], 16'hE000);
      rd_chk("break done", `UCD_ADDR_OPT, 8'h00);
   endtask

   task automatic t_brk;
      logic got;
      cfg(8'hF2, 8'h00, 8'h04, 8'h04);
      fork
         i_remote.send(16'h0000, 14);
         wait_irq(1'b0, 80, got);
      join
      check("break no data", 16'(got), 16'h0);
      rd_chk("break flag", `UCD_ADDR_STS, 8'h08);
      reg_wr(`UCD_ADDR_STS, 8'h08);
      rd_chk("break clear", `UCD_ADDR_STS, 8'h00);
   endtask

   task automatic t_off;
      reg_wr(`UCD_ADDR_CTL, 8'h00);
      repeat (2) @(posedge clk);
      check("off high", 16'(txd), 16'h1);
      reg_wr(`UCD_ADDR_OPT, 8'h02);
      repeat (2) @(posedge clk);
      check("off inverted", 16'(txd), 16'h0);
      rd_chk("opt back", `UCD_ADDR_OPT, 8'h02);
   endtask

   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      n_fail++;
      stop_test;
   end

   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext_sclk = 1'b0;
      ext_on = 1'b0;
      bit_len = 8'h04;
      nbits = 4'hA;
      n_fail = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_tx(8'hF2, 8'h00, 8'h04, 8'h04, 8'hA5, 8'h5A);
      t_tx(8'hED, 8'h00, 8'h04, 8'h04, 8'h35, 8'h4A);
      t_tx(8'hE8, 8'h01, 8'h05, 8'h0A, 8'h81, 8'h7E);
      ext_on = 1'b1;
      t_tx(8'hF7, 8'h0B, 8'h04, 8'h08, 8'hC3, 8'h3C);
      ext_on = 1'b0;
      t_rx(8'hF2, 8'h3C, 2'b00, 8'h00);
      t_rx(8'hED, 8'h35, 2'b00, 8'h00);
      t_rx(8'hE8, 8'h52, 2'b00, 8'h00);
      t_rx(8'hF7, 8'hA1, 2'b00, 8'h00);
      t_rx(8'hEE, 8'h96, 2'b01, 8'h04);
      t_rx(8'hF2, 8'h41, 2'b10, 8'h02);
      t_rx(8'hD2, 8'h77, 2'b00, 8'h00);
      t_ovr;
      t_sbt;
      t_brk;
      t_off;
      stop_test;
   end
endmodule
